//--- core/v5hc_codec.v
// How it works
// - Entity address is 13 bits; values up to 8175 mean user ports, never entities.
// - Entities: 8176 PSTN, 8177 control, 8178 BCC, 8179 protection, 8180 link control.
// - Octet 1 holds six high bits, C/R, EA; octet 2 seven low bits, EA.
// - Message is discriminator, two-octet layer 3 address, message type, then elements.
// - Header elements always present, recognised only by their octet position.
// - Each information element appears at most once in a message.
// - Bit 1 of each octet goes first; octets go in ascending order.
// - Multi-octet fields put most significant bits in the lowest-numbered octet.
// - Reserved bits sent as zero; nonzero reserved bits received are accepted.
// - Discriminator is sent as 0x48; other values are not V5.
// - Messages with another discriminator are routed away from V5 handlers.
// - Layer 3 address is two octets after discriminator, passed on unparsed.
// - Message type bit 8 zero; bits 7..5 and 4 pick the family.
`timescale 1ns/1ns
`include "v5hc_map.vh"
module v5hc_codec #(
  parameter FIFO_D  = `V5HC_FIFO_D,
  parameter FIFO_AW = `V5HC_FIFO_AW
) (
  input  wire        clk,           // System clock, 250 MHz
  input  wire        rst_n,         // Async reset, active low
  input  wire        tx_start,      // Begin a message, taken when idle
  input  wire [2:0]  tx_entity,     // Protocol entity, 0..4
  input  wire        tx_cr,         // Command/response bit
  input  wire [15:0] tx_l3_addr,    // Layer 3 address, high octet first
  input  wire [7:0]  tx_msg_type,   // Message type
  input  wire        tx_has_pl,     // Payload octets follow the header
  output wire        tx_busy,       // Message in progress
  output reg         tx_reject_q,   // Start refused, one-cycle pulse
  input  wire [7:0]  tx_pl_data,    // Payload octet
  input  wire        tx_pl_valid,   // Payload octet valid
  input  wire        tx_pl_last,    // Final payload octet
  output wire        tx_pl_ready,   // Payload octet taken
  output reg  [7:0]  link_tx_data_q,// Octet to peer, bit 1 in bit 0
  output reg         link_tx_valid_q,// Octet valid
  output reg         link_tx_last_q,// Final octet of message
  input  wire        link_tx_ready, // Peer takes octet
  input  wire [7:0]  link_rx_data,  // Octet from peer, bit 1 in bit 0
  input  wire        link_rx_valid, // Octet valid
  input  wire        link_rx_last,  // Final octet of message
  output wire        link_rx_ready, // Octet taken
  output reg         rx_hdr_valid_q,// Header complete, one-cycle pulse
  output reg  [1:0]  rx_route_q,    // V5, foreign, user port, reserved
  output reg  [12:0] rx_dl_addr_q,  // Data-link entity address
  output reg         rx_cr_q,       // Command/response bit
  output reg  [2:0]  rx_entity_q,   // Entity index, 7 if none
  output reg  [15:0] rx_l3_addr_q,  // Layer 3 address
  output reg  [7:0]  rx_msg_type_q, // Message type
  output reg  [2:0]  rx_mt_family_q,// Message type family
  output reg         rx_no_pl_q,    // No payload follows
  output reg         rx_hdr_err_q,  // Short message dropped, one-cycle pulse
  output wire [7:0]  rx_pl_data,    // Payload octet
  output wire        rx_pl_valid,   // Payload octet valid
  output wire        rx_pl_last,    // Final payload octet
  input  wire        rx_pl_ready    // Payload octet taken
);

  function [2:0] mt_family;
    input [7:0] mt;
    begin
      mt_family = `V5HC_FAM_RSVD;
      if (!mt[`V5HC_MT_ZERO_BIT]) begin
        case (mt[6:4])
          3'h0:    mt_family = `V5HC_FAM_PSTN;
          3'h1:    mt_family = mt[3] ? `V5HC_FAM_PROT : `V5HC_FAM_CTRL;
          3'h2:    mt_family = `V5HC_FAM_BCC;
          3'h3:    mt_family = mt[3] ? `V5HC_FAM_RSVD : `V5HC_FAM_LINK;
          default: mt_family = `V5HC_FAM_RSVD;
        endcase
      end
    end
  endfunction

  // Transmit side
  reg  [2:0]  ts_q;
  reg  [2:0]  ts_d;
  reg  [12:0] t_addr_q;
  reg         t_cr_q;
  reg  [15:0] t_l3_q;
  reg  [7:0]  t_mt_q;
  reg         t_pl_q;
  reg  [7:0]  o_data_d;
  reg         o_valid_d;
  reg         o_last_d;
  wire        slot_free;
  wire        start_ok;

  assign slot_free   = ~link_tx_valid_q | link_tx_ready;
  assign tx_busy     = (ts_q != `V5HC_TS_IDLE);
  assign tx_pl_ready = (ts_q == `V5HC_TS_PL) & slot_free;
  // Entities above 4 would map into the reserved range above link control
  assign start_ok    = (tx_entity <= `V5HC_ENT_MAX) &&
                       (mt_family({1'b0, tx_msg_type[6:0]}) != `V5HC_FAM_RSVD);

  always @* begin
    ts_d      = ts_q;
    o_data_d  = link_tx_data_q;
    o_valid_d = link_tx_valid_q & ~link_tx_ready;
    o_last_d  = link_tx_last_q;
    if (slot_free) begin
      o_last_d = 1'b0;
      // Ascending octet order; link_tx_data bit 0 is bit 1 and leaves first
      case (ts_q)
        `V5HC_TS_IDLE: begin
          ts_d = `V5HC_TS_IDLE;
        end
        `V5HC_TS_A1: begin
          o_data_d  = {t_addr_q[12:7], t_cr_q, 1'b0};
          o_valid_d = 1'b1;
          ts_d      = `V5HC_TS_A2;
        end
        `V5HC_TS_A2: begin
          o_data_d  = {t_addr_q[6:0], 1'b1};
          o_valid_d = 1'b1;
          ts_d      = `V5HC_TS_PD;
        end
        `V5HC_TS_PD: begin
          o_data_d  = `V5HC_PD_VALUE;
          o_valid_d = 1'b1;
          ts_d      = `V5HC_TS_L3H;
        end
        `V5HC_TS_L3H: begin
          o_data_d  = t_l3_q[15:8];
          o_valid_d = 1'b1;
          ts_d      = `V5HC_TS_L3L;
        end
        `V5HC_TS_L3L: begin
          o_data_d  = t_l3_q[7:0];
          o_valid_d = 1'b1;
          ts_d      = `V5HC_TS_MT;
        end
        `V5HC_TS_MT: begin
          o_data_d  = {1'b0, t_mt_q[6:0]};
          o_valid_d = 1'b1;
          o_last_d  = ~t_pl_q;
          ts_d      = t_pl_q ? `V5HC_TS_PL : `V5HC_TS_IDLE;
        end
        `V5HC_TS_PL: begin
          // Elements are the user's; each header element goes out once
          o_valid_d = tx_pl_valid;
          if (tx_pl_valid) begin
            o_data_d = tx_pl_data;
            o_last_d = tx_pl_last;
            if (tx_pl_last) begin
              ts_d = `V5HC_TS_IDLE;
            end
          end
        end
        default: begin
          ts_d      = `V5HC_TS_IDLE;
          o_valid_d = 1'b0;
        end
      endcase
    end
    if (ts_q == `V5HC_TS_IDLE && tx_start && start_ok) begin
      ts_d = `V5HC_TS_A1;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ts_q            <= `V5HC_TS_IDLE;
      t_addr_q        <= `V5HC_DLA_BASE;
      t_cr_q          <= 1'b0;
      t_l3_q          <= 16'h0000;
      t_mt_q          <= 8'h00;
      t_pl_q          <= 1'b0;
      tx_reject_q     <= 1'b0;
      link_tx_data_q  <= 8'h00;
      link_tx_valid_q <= 1'b0;
      link_tx_last_q  <= 1'b0;
    end else begin
      ts_q            <= ts_d;
      link_tx_data_q  <= o_data_d;
      link_tx_valid_q <= o_valid_d;
      link_tx_last_q  <= o_last_d;
      tx_reject_q     <= (ts_q == `V5HC_TS_IDLE) & tx_start & ~start_ok;
      if (ts_q == `V5HC_TS_IDLE && tx_start && start_ok) begin
        t_addr_q <= `V5HC_DLA_BASE + {10'h000, tx_entity};
        t_cr_q   <= tx_cr;
        t_l3_q   <= tx_l3_addr;
        t_mt_q   <= tx_msg_type;
        t_pl_q   <= tx_has_pl;
      end
    end
  end

  // Receive side
  reg  [2:0]  rs_q;
  reg  [7:0]  a1_q;
  wire        rx_take;
  wire [12:0] rx_addr_w;
  wire        addr_user;
  wire        addr_ent;
  wire [12:0] ent_off;
  wire        fifo_in_ready;
  wire        fifo_empty;
  wire [8:0]  fifo_out;
  wire        fifo_push;

  // A new message waits for the buffer to drain so header and payload stay paired
  assign link_rx_ready = (rs_q == `V5HC_RS_A1) ? fifo_empty :
                         (rs_q == `V5HC_RS_PL) ? fifo_in_ready : 1'b1;
  assign rx_take   = link_rx_valid & link_rx_ready;
  assign rx_addr_w = {a1_q[`V5HC_A1_HI_MSB:`V5HC_A1_HI_LSB],
                      link_rx_data[`V5HC_A2_LO_MSB:`V5HC_A2_LO_LSB]};
  assign addr_user = (rx_addr_w < `V5HC_DLA_BASE);
  assign addr_ent  = (rx_addr_w >= `V5HC_DLA_PSTN) && (rx_addr_w <= `V5HC_DLA_LINK);
  assign ent_off   = rx_addr_w - `V5HC_DLA_BASE;
  assign fifo_push = rx_take & (rs_q == `V5HC_RS_PL);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rs_q           <= `V5HC_RS_A1;
      a1_q           <= 8'h00;
      rx_hdr_valid_q <= 1'b0;
      rx_route_q     <= `V5HC_RT_V5;
      rx_dl_addr_q   <= 13'h0000;
      rx_cr_q        <= 1'b0;
      rx_entity_q    <= `V5HC_ENT_NONE;
      rx_l3_addr_q   <= 16'h0000;
      rx_msg_type_q  <= 8'h00;
      rx_mt_family_q <= `V5HC_FAM_RSVD;
      rx_no_pl_q     <= 1'b0;
      rx_hdr_err_q   <= 1'b0;
    end else begin
      rx_hdr_valid_q <= 1'b0;
      rx_hdr_err_q   <= 1'b0;
      if (rx_take) begin
        // Header found by position only; extension bits and reserved bits not policed
        case (rs_q)
          `V5HC_RS_A1: begin
            a1_q    <= link_rx_data;
            rx_cr_q <= link_rx_data[`V5HC_A1_CR];
            if (link_rx_last) begin
              rx_hdr_err_q <= 1'b1;
            end else begin
              rs_q <= `V5HC_RS_A2;
            end
          end
          `V5HC_RS_A2: begin
            rx_dl_addr_q <= rx_addr_w;
            rx_entity_q  <= addr_ent ? ent_off[2:0] : `V5HC_ENT_NONE;
            if (addr_user) begin
              // User-port frame: no layer 3 header to parse
              rx_route_q     <= `V5HC_RT_USER;
              rx_no_pl_q     <= link_rx_last;
              rx_hdr_valid_q <= 1'b1;
              rs_q           <= link_rx_last ? `V5HC_RS_A1 : `V5HC_RS_PL;
            end else if (link_rx_last) begin
              rx_hdr_err_q <= 1'b1;
              rs_q         <= `V5HC_RS_A1;
            end else begin
              rs_q <= `V5HC_RS_PD;
            end
          end
          `V5HC_RS_PD: begin
            if (link_rx_data != `V5HC_PD_VALUE) begin
              // Foreign protocol: hand the rest over raw, away from V5 handlers
              rx_route_q     <= `V5HC_RT_FOREIGN;
              rx_no_pl_q     <= link_rx_last;
              rx_hdr_valid_q <= 1'b1;
              rs_q           <= link_rx_last ? `V5HC_RS_A1 : `V5HC_RS_PL;
            end else if (link_rx_last) begin
              rx_hdr_err_q <= 1'b1;
              rs_q         <= `V5HC_RS_A1;
            end else begin
              rs_q <= `V5HC_RS_L3H;
            end
          end
          `V5HC_RS_L3H: begin
            rx_l3_addr_q[15:8] <= link_rx_data;
            if (link_rx_last) begin
              rx_hdr_err_q <= 1'b1;
              rs_q         <= `V5HC_RS_A1;
            end else begin
              rs_q <= `V5HC_RS_L3L;
            end
          end
          `V5HC_RS_L3L: begin
            rx_l3_addr_q[7:0] <= link_rx_data;
            if (link_rx_last) begin
              rx_hdr_err_q <= 1'b1;
              rs_q         <= `V5HC_RS_A1;
            end else begin
              rs_q <= `V5HC_RS_MT;
            end
          end
          `V5HC_RS_MT: begin
            rx_msg_type_q  <= link_rx_data;
            rx_mt_family_q <= mt_family(link_rx_data);
            rx_route_q     <= (rx_entity_q == `V5HC_ENT_NONE) ? `V5HC_RT_RSVD : `V5HC_RT_V5;
            rx_no_pl_q     <= link_rx_last;
            rx_hdr_valid_q <= 1'b1;
            rs_q           <= link_rx_last ? `V5HC_RS_A1 : `V5HC_RS_PL;
          end
          `V5HC_RS_PL: begin
            if (link_rx_last) begin
              rs_q <= `V5HC_RS_A1;
            end
          end
          default: begin
            rs_q <= `V5HC_RS_A1;
          end
        endcase
      end
    end
  end

  v5hc_fifo #(
    .W  (`V5HC_FIFO_W),
    .D  (FIFO_D),
    .AW (FIFO_AW)
  ) u_rx_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   ({link_rx_last, link_rx_data}),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (rx_pl_valid),
    .out_ready (rx_pl_ready),
    .empty     (fifo_empty)
  );

  assign rx_pl_data = fifo_out[7:0];
  assign rx_pl_last = fifo_out[8];
endmodule

//--- core/v5hc_fifo.v
`timescale 1ns/1ns
module v5hc_fifo #(
  parameter W  = 9,
  parameter D  = 16,
  parameter AW = 4
) (
  input  wire         clk,      // System clock
  input  wire         rst_n,    // Async reset, active low
  input  wire [W-1:0] in_data,  // Write word
  input  wire         in_valid, // Write request
  output wire         in_ready, // Not full
  output wire [W-1:0] out_data, // Head word
  output wire         out_valid,// Not empty
  input  wire         out_ready,// Read accept
  output wire         empty     // No words held
);
  reg [W-1:0] mem_q [0:D-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0]   cnt_q;
  wire         push;
  wire         pop;

  assign in_ready  = (cnt_q != D[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign empty     = ~out_valid;
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      // Depth need not be a power of two
      if (push) begin
        wr_q <= (wr_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

//--- pkg/v5hc_map.vh
`ifndef V5HC_MAP_VH
`define V5HC_MAP_VH

// Data-link entity addresses, 13 bits
`define V5HC_DLA_W          13
`define V5HC_DLA_BASE       13'h1ff0
`define V5HC_DLA_PSTN       13'h1ff0
`define V5HC_DLA_CTRL       13'h1ff1
`define V5HC_DLA_BCC        13'h1ff2
`define V5HC_DLA_PROT       13'h1ff3
`define V5HC_DLA_LINK       13'h1ff4
`define V5HC_ENT_MAX        3'h4
`define V5HC_ENT_NONE       3'h7

// Address octet field positions
`define V5HC_A1_HI_MSB      7
`define V5HC_A1_HI_LSB      2
`define V5HC_A1_CR          1
`define V5HC_A2_LO_MSB      7
`define V5HC_A2_LO_LSB      1
`define V5HC_EA_BIT         0

// Layer 3 header
`define V5HC_PD_VALUE       8'h48
`define V5HC_MT_ZERO_BIT    7

// Message type families
`define V5HC_FAM_PSTN       3'h0
`define V5HC_FAM_CTRL       3'h1
`define V5HC_FAM_PROT       3'h2
`define V5HC_FAM_BCC        3'h3
`define V5HC_FAM_LINK       3'h4
`define V5HC_FAM_RSVD       3'h7

// Receive routes
`define V5HC_RT_V5          2'h0
`define V5HC_RT_FOREIGN     2'h1
`define V5HC_RT_USER        2'h2
`define V5HC_RT_RSVD        2'h3

// Transmit states
`define V5HC_TS_IDLE        3'h0
`define V5HC_TS_A1          3'h1
`define V5HC_TS_A2          3'h2
`define V5HC_TS_PD          3'h3
`define V5HC_TS_L3H         3'h4
`define V5HC_TS_L3L         3'h5
`define V5HC_TS_MT          3'h6
`define V5HC_TS_PL          3'h7

// Receive states
`define V5HC_RS_A1          3'h0
`define V5HC_RS_A2          3'h1
`define V5HC_RS_PD          3'h2
`define V5HC_RS_L3H         3'h3
`define V5HC_RS_L3L         3'h4
`define V5HC_RS_MT          3'h5
`define V5HC_RS_PL          3'h6

// Payload buffer
`define V5HC_FIFO_W         9
`define V5HC_FIFO_D         16
`define V5HC_FIFO_AW        4

`endif

//--- tb/v5hc_codec_assertions.sv
`timescale 1ns/1ns
module v5hc_chk (
  input wire       clk,             // Clock
  input wire       rst_n,           // Reset, active low
  input wire       tx_start,        // Start request
  input wire [2:0] tx_entity,       // Entity index
  input wire [7:0] tx_msg_type,     // Message type
  input wire       tx_busy,         // Sending
  input wire       tx_reject_q,     // Start refused
  input wire [7:0] link_tx_data_q,  // Octet out
  input wire       link_tx_valid_q, // Octet valid
  input wire       link_tx_last_q,  // Final octet
  input wire       link_tx_ready,   // Peer takes
  input wire       rx_hdr_err_q,    // Short message
  input wire       link_rx_valid,   // Octet in valid
  input wire       link_rx_ready,   // Octet in taken
  input wire       link_rx_last,    // Final octet in
  input wire       rx_pl_valid      // Payload out valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  reg  [2:0] n_q;
  wire       tk = link_tx_valid_q & link_tx_ready;
  // Octet index within the message, saturates in the payload
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      n_q <= 3'h0;
    else if (tk)
      n_q <= link_tx_last_q ? 3'h0 : (n_q == 3'h7 ? n_q : n_q + 3'h1);
  end
  a1_octet_a: assert property (link_tx_valid_q && n_q == 3'h0 |->
    link_tx_data_q[7:2] == 6'h3f && !link_tx_data_q[0]) else $error("bad address octet 1");
  a2_octet_a: assert property (link_tx_valid_q && n_q == 3'h1 |->
    link_tx_data_q[0] && link_tx_data_q[7:1] inside {[7'h70:7'h74]}) else $error("bad octet 2");
  pd_octet_a: assert property (link_tx_valid_q && n_q == 3'h2 |->
    link_tx_data_q == 8'h48) else $error("bad discriminator");
  mt_bit_a: assert property (link_tx_valid_q && n_q == 3'h5 |->
    !link_tx_data_q[7]) else $error("message type bit 8 set");
  hold_out_a: assert property (link_tx_valid_q && !link_tx_ready |=>
    link_tx_valid_q && $stable(link_tx_data_q) && $stable(link_tx_last_q))
    else $error("octet changed while stalled");
  refuse_ent_a: assert property (tx_start && !tx_busy && tx_entity > 3'h4 |=>
    tx_reject_q && !tx_busy) else $error("bad entity not refused");
  start_ok_a: assert property (tx_start && !tx_busy && tx_entity <= 3'h4 &&
    tx_msg_type[6:4] == 3'h0 |=> tx_busy ##1 link_tx_valid_q) else $error("start not taken");
  // Back-to-back one-octet messages give adjacent pulses, so tie each to its ending octet
  err_pulse_a: assert property (rx_hdr_err_q |->
    $past(link_rx_valid && link_rx_ready && link_rx_last))
    else $error("header error without an ending octet");
  err_drop_a: assert property (rx_hdr_err_q |-> !rx_pl_valid)
    else $error("short message forwarded");
  cover property (tk && link_tx_last_q);
  cover property (tx_reject_q);
  cover property (rx_hdr_err_q);
endmodule
bind v5hc_codec v5hc_chk u_chk (.clk(clk), .rst_n(rst_n), .tx_start(tx_start),
  .tx_entity(tx_entity), .tx_msg_type(tx_msg_type), .tx_busy(tx_busy),
  .tx_reject_q(tx_reject_q), .link_tx_data_q(link_tx_data_q),
  .link_tx_valid_q(link_tx_valid_q), .link_tx_last_q(link_tx_last_q),
  .link_tx_ready(link_tx_ready), .rx_hdr_err_q(rx_hdr_err_q), .rx_pl_valid(rx_pl_valid),
  .link_rx_valid(link_rx_valid), .link_rx_ready(link_rx_ready), .link_rx_last(link_rx_last));

//--- tb/v5hc_codec_tb.sv
`timescale 1ns/1ns
module v5hc_codec_tb;
  logic        clk, rst_n, tx_start, tx_cr, tx_has_pl, tx_busy, tx_reject_q, slow;
  logic [2:0]  tx_entity, rx_entity_q, rx_mt_family_q;
  logic [15:0] tx_l3_addr, rx_l3_addr_q;
  logic [7:0]  tx_msg_type, tx_pl_data, lt_data, lr_data, rx_msg_type_q, rx_pl_data;
  logic        tx_pl_valid, tx_pl_last, tx_pl_ready, lt_valid, lt_last, lt_ready;
  logic        lr_valid, lr_last, lr_ready, rx_hdr_valid_q, rx_cr_q, rx_no_pl_q, rx_hdr_err_q;
  logic        rx_pl_valid, rx_pl_last, rx_pl_ready;
  logic [1:0]  rx_route_q;
  logic [12:0] rx_dl_addr_q;
  integer      bad_count, check_count, cyc, hv, he, e, h0;
  logic [8:0]  rq[$];
  logic [7:0]  ex[$];
  logic [7:0]  mts[0:4];
  v5hc_codec #(.FIFO_D(16), .FIFO_AW(4)) uut (.clk(clk), .rst_n(rst_n), .tx_start(tx_start),
    .tx_entity(tx_entity), .tx_cr(tx_cr), .tx_l3_addr(tx_l3_addr), .tx_msg_type(tx_msg_type),
    .tx_has_pl(tx_has_pl), .tx_busy(tx_busy), .tx_reject_q(tx_reject_q),
    .tx_pl_data(tx_pl_data), .tx_pl_valid(tx_pl_valid), .tx_pl_last(tx_pl_last),
    .tx_pl_ready(tx_pl_ready), .link_tx_data_q(lt_data), .link_tx_valid_q(lt_valid),
    .link_tx_last_q(lt_last), .link_tx_ready(lt_ready), .link_rx_data(lr_data),
    .link_rx_valid(lr_valid), .link_rx_last(lr_last), .link_rx_ready(lr_ready),
    .rx_hdr_valid_q(rx_hdr_valid_q), .rx_route_q(rx_route_q), .rx_dl_addr_q(rx_dl_addr_q),
    .rx_cr_q(rx_cr_q), .rx_entity_q(rx_entity_q), .rx_l3_addr_q(rx_l3_addr_q),
    .rx_msg_type_q(rx_msg_type_q), .rx_mt_family_q(rx_mt_family_q), .rx_no_pl_q(rx_no_pl_q),
    .rx_hdr_err_q(rx_hdr_err_q), .rx_pl_data(rx_pl_data), .rx_pl_valid(rx_pl_valid),
    .rx_pl_last(rx_pl_last), .rx_pl_ready(rx_pl_ready));
  v5hc_peer peer (.clk(clk), .rst_n(rst_n), .tx_data(lt_data), .tx_valid(lt_valid),
    .tx_last(lt_last), .tx_ready(lt_ready), .rx_data(lr_data), .rx_valid(lr_valid),
    .rx_last(lr_last), .rx_ready(lr_ready), .slow(slow));
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rx_hdr_valid_q === 1'b1) hv <= hv + 1;
    if (rx_hdr_err_q === 1'b1) he <= he + 1;
    if (rx_pl_valid === 1'b1 && rx_pl_ready === 1'b1) rq.push_back({rx_pl_last, rx_pl_data});
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      summarize;
    end
  end
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task summarize;
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task send_tx(input logic [2:0] en, input logic c, input logic [15:0] l3,
               input logic [7:0] mt, input integer npl);
    integer k;
    logic [12:0] da;
    peer.got.delete();
    da = 13'h1ff0 + en;
    @(negedge clk);
    tx_entity = en;
    tx_cr = c;
    tx_l3_addr = l3;
    tx_msg_type = mt;
    tx_has_pl = (npl > 0);
    tx_start = 1'b1;
    @(negedge clk);
    tx_start = 1'b0;
    for (k = 0; k < npl; k++) begin
      tx_pl_data = 8'ha0 + k[7:0];
      tx_pl_valid = 1'b1;
      tx_pl_last = (k == npl - 1);
      // Ready is judged at the taking edge; the peer's stall toggles at the falling edge
      do @(posedge clk); while (tx_pl_ready !== 1'b1);
      @(negedge clk);
    end
    tx_pl_valid = 1'b0;
    tx_pl_last = 1'b0;
    for (k = 0; k < 200 && peer.got.size() < 6 + npl; k++) @(negedge clk);
    ex = '{{6'h3f, c, 1'b0}, {da[6:0], 1'b1}, 8'h48, l3[15:8], l3[7:0], {1'b0, mt[6:0]}};
    for (k = 0; k < npl; k++) ex.push_back(8'ha0 + k[7:0]);
    chk("tx octet count", peer.got.size(), ex.size());
    for (k = 0; k < ex.size() && k < peer.got.size(); k++)
      chk("tx octet", peer.got[k], {k == ex.size() - 1, ex[k]});
  endtask
  task t_tx_families;
    mts = '{8'h85, 8'h12, 8'h1b, 8'h27, 8'h31};
    for (e = 0; e < 5; e++) begin
      slow = e[0];
      send_tx(e[2:0], e[0], 16'h1234 + e[15:0], mts[e], 0);
    end
  endtask
  task t_tx_payload;
    slow = 1'b1;
    send_tx(3'h4, 1'b1, 16'hbeef, 8'h30, 3);
    slow = 1'b0;
  endtask
  task t_reject;
    peer.got.delete();
    mts[0] = 8'h05;
    mts[1] = 8'h38;
    for (e = 0; e < 2; e++) begin
      @(negedge clk);
      tx_entity = e ? 3'h1 : 3'h5;
      tx_msg_type = mts[e];
      tx_start = 1'b1;
      @(negedge clk);
      tx_start = 1'b0;
      chk("tx refused", tx_reject_q, 1'b1);
    end
    repeat (10) @(negedge clk);
    chk("refused octets", peer.got.size(), 0);
  endtask
  task t_rx_fill;
    rq.delete();
    rx_pl_ready = 1'b0;
    h0 = hv;
    peer.msg = '{8'hff, 8'he7, 8'h48, 8'h12, 8'h34, 8'h2a};
    for (e = 0; e < 20; e++) peer.msg.push_back(8'h50 + e[7:0]);
    fork
      peer.send;
      begin
        repeat (60) @(negedge clk);
        chk("link stalled on full buffer", lr_ready, 1'b0);
        rx_pl_ready = 1'b1;
        for (e = 0; e < 200 && rq.size() < 20; e++) @(negedge clk);
      end
    join
    chk("header pulses", hv - h0, 1);
    chk("route", rx_route_q, 2'h0);
    chk("dl address", rx_dl_addr_q, 13'h1ff3);
    chk("cr and entity", {rx_cr_q, rx_entity_q}, 4'hb);
    chk("l3 address", rx_l3_addr_q, 16'h1234);
    chk("family", rx_mt_family_q, 3'h3);
    chk("message type", rx_msg_type_q, 8'h2a);
    chk("payload count", rq.size(), 20);
    for (e = 0; e < rq.size(); e++) chk("payload", rq[e], {e == 19, 8'h50 + e[7:0]});
  endtask
  task run_rx;
    rq.delete();
    h0 = hv + 4 * he;
    peer.send;
    repeat (4) @(negedge clk);
  endtask
  task t_rx_misc;
    peer.msg = '{8'hfc, 8'he1, 8'h45, 8'h11};
    run_rx;
    chk("foreign route", {hv + 4 * he - h0, rx_route_q}, 3'h5);
    chk("foreign octet", rq[0], 9'h111);
    peer.msg = '{8'h00, 8'h21, 8'h77};
    run_rx;
    chk("user route", {rx_route_q, rx_dl_addr_q}, {2'h2, 13'h0010});
    chk("user octet", rq[0], 9'h177);
    peer.msg = '{8'hfc, 8'he1, 8'h48, 8'h12};
    run_rx;
    chk("short message", (hv + 4 * he - h0) * 256 + rq.size(), 16'h0400);
    peer.msg = '{8'hfc, 8'he1, 8'h48, 8'h00, 8'h05, 8'h02};
    run_rx;
    chk("header only", {rx_no_pl_q, rx_entity_q, rx_mt_family_q}, 7'h40);
    peer.msg = '{8'hfc, 8'heb, 8'h48, 8'h00, 8'h05, 8'h02};
    run_rx;
    chk("reserved address", {rx_route_q, rx_entity_q}, 5'h1f);
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {tx_start, tx_cr, tx_has_pl, tx_pl_valid, tx_pl_last, rx_pl_ready, slow} = 7'h00;
    {tx_entity, tx_l3_addr, tx_msg_type, tx_pl_data} = 35'h0;
    {bad_count, check_count, cyc, hv, he} = {5{32'h0}};
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_tx_families;
    t_tx_payload;
    t_reject;
    t_rx_fill;
    t_rx_misc;
    summarize;
  end
endmodule

//--- tb/v5hc_peer.sv
`timescale 1ns/1ns
module v5hc_peer (
  input  wire       clk,      // Clock
  input  wire       rst_n,    // Reset, active low
  input  wire [7:0] tx_data,  // Octet from block
  input  wire       tx_valid, // Octet valid
  input  wire       tx_last,  // Final octet
  output reg        tx_ready, // Take octet
  output reg  [7:0] rx_data,  // Octet to block
  output reg        rx_valid, // Octet valid
  output reg        rx_last,  // Final octet
  input  wire       rx_ready, // Block took octet
  input  wire       slow      // Stall every other cycle
);
  logic [8:0] got[$];
  logic [7:0] msg[$];
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_last = 1'b0;
  end
  // Alternate stalls exercise the block's output hold
  always @(negedge clk) tx_ready <= !rst_n ? 1'b0 : (slow ? !tx_ready : 1'b1);
  always @(posedge clk) if (tx_valid && tx_ready) got.push_back({tx_last, tx_data});
  // Message sent whole, octet 1 first; released line shows the inverse
  task send;
    integer i;
    for (i = 0; i < msg.size(); i++) begin
      @(negedge clk);
      rx_data = msg[i];
      rx_valid = 1'b1;
      rx_last = (i == msg.size() - 1);
      while (rx_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_last = 1'b0;
    rx_data = ~rx_data;
  endtask
endmodule
